/* verilog/acs_sequencer.sv */
// Converter control sequencer with AHB-Lite register slave
//
// The address map and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

// How it works
// - A start bit written high then low begins one conversion.
// - Busy flag goes to one once a conversion has been started.
// - Busy flag returns to zero when the conversion is complete.
// - Result format zero packs 11..4 high, one packs 11..8 high.
// - Source codes 0000, 0100 and 11xx route the external channel.
// - Codes 0001 to 0011 pick supply, half supply, quarter supply.
// - Codes 0101 to 0111 pick amplifier output, half, quarter.
// - Codes 10xx tie the converter input to ground.
// - Any internal source disconnects the external channel.
// - Channel codes 1000 to 1111 select nothing, input floats.
// - Conversion clock toggles every two to the code system clocks.
// - Unimplemented control bits read as zero.
// - Amplifier input is reference pin at zero, bandgap at one.
// - Bandgap feeding the amplifier disconnects the reference pin.
// - Reference is supply at 00, pin at 01, amplifier at 1x.
// - Amplified internal reference disconnects the reference pin.
// - Channel codes 0000 to 0111 pick analog channels 0 to 7.
// - Gain select sets gain 1, 1.667, 2.5 or 3.333.
// - With the converter disabled the result bytes stay unchanged.
// - Each completed conversion raises the interrupt request flag.
module acs_sequencer (
	input  wire logic                 ref_clk_i,
	input  wire logic                 nrst_i,
	input  wire logic                 hsel_i,
	input  wire logic [11:0]          haddr_i,
	input  wire logic [1:0]           htrans_i,
	input  wire logic                 hwrite_i,
	input  wire logic [2:0]           hsize_i,
	input  wire logic [31:0]          hwdata_i,
	input  wire logic                 hready_i,
	input  wire logic                 sar_bit_i,
	output logic      [31:0]          hrdata_o,
	output logic                      hreadyout_o,
	output logic                      hresp_o,
	output logic                      conv_clk_o,
	output logic                      sample_o,
	output logic                      sar_trial_o,
	output logic      [11:0]          sar_code_o,
	output logic                      conv_done_irq_o,
	output acs_pkg::acs_analog_t      analog_ctrl_o,
	output acs_pkg::acs_result_t      result_o
);
	import acs_pkg::*;

	typedef enum logic [1:0] {
		ACS_IDLE,
		ACS_SAMPLE,
		ACS_CONVERT
	} acs_state_t;

	logic [7:0]  main_r;
	logic [7:0]  inclk_r;
	logic [7:0]  refgain_r;
	logic [7:0]  bandgap_r;
	logic        start_seen_r;
	logic        busy_r;
	logic        irq_r;
	acs_state_t  state_r;
	logic [6:0]  div_cnt_r;
	logic        conv_clk_r;
	logic [4:0]  step_r;
	logic [11:0] sar_r;
	logic [11:0] data_r;
	acs_result_t result_r;
	acs_analog_t analog_r;
	logic [31:0] hrdata_r;
	logic        wr_pend_r;
	logic [11:0] wr_addr_r;

	logic        addr_ok;
	logic        wr_main;
	logic        start_pulse;
	logic        tick;
	logic [6:0]  div_limit;
	logic [3:0]  bit_idx;
	acs_analog_t analog_nxt;
	logic [2:0]  chan_sel;
	logic        chan_none;
	logic [3:0]  src_sel;
	logic [2:0]  div_sel;
	logic [1:0]  ref_sel;
	logic [1:0]  gain_sel;
	logic        amp_en;
	logic        amp_in_sel;
	logic        bg_en;
	logic        sample_last;
	logic        conv_last;

	// Word aligned register decode
	function automatic logic sel_reg(input logic [11:0] a,
		input logic [3:0] off);
		sel_reg = (a[11:4] == 8'h00) && (a[3:0] == off);
	endfunction

	function automatic logic [7:0] merge(input logic [7:0] cur,
		input logic [7:0] wd, input logic [7:0] msk);
		merge = (cur & ~msk) | (wd & msk);
	endfunction

	assign addr_ok = hsel_i && hready_i && (htrans_i == HTRANS_NONSEQ);
	assign wr_main = wr_pend_r && sel_reg(wr_addr_r, OFF_MAIN);

	// Named views of the control fields
	assign chan_sel   = main_r[FLD_CHAN +: 3];
	assign chan_none  = main_r[BIT_NO_CHAN];
	assign src_sel    = inclk_r[FLD_SRC +: 4];
	assign div_sel    = inclk_r[FLD_DIV +: 3];
	assign ref_sel    = refgain_r[FLD_REF +: 2];
	assign gain_sel   = refgain_r[FLD_GAIN +: 2];
	assign amp_en     = refgain_r[BIT_AMP_EN];
	assign amp_in_sel = refgain_r[BIT_AMP_IN];
	assign bg_en      = bandgap_r[BIT_BG_EN];

	// Start must go high then be written low again
	assign start_pulse = wr_main && start_seen_r && !hwdata_i[BIT_START]
		&& main_r[BIT_ENABLE] && !busy_r;

	// Write data phase follows the address phase by one cycle
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 12'h000;
		end else begin
			wr_pend_r <= addr_ok && hwrite_i && (hsize_i == HSIZE_WORD);
			wr_addr_r <= haddr_i;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			main_r    <= REG_RESET;
			inclk_r   <= REG_RESET;
			refgain_r <= REG_RESET;
			bandgap_r <= REG_RESET;
		end else if (wr_pend_r) begin
			if (sel_reg(wr_addr_r, OFF_MAIN))
				main_r <= merge(main_r, hwdata_i[7:0], MAIN_WMASK);
			if (sel_reg(wr_addr_r, OFF_INCLK))
				inclk_r <= merge(inclk_r, hwdata_i[7:0], INCLK_WMASK);
			if (sel_reg(wr_addr_r, OFF_REFGAIN))
				refgain_r <= merge(refgain_r, hwdata_i[7:0],
					REFGAIN_WMASK);
			if (sel_reg(wr_addr_r, OFF_BANDGAP))
				bandgap_r <= merge(bandgap_r, hwdata_i[7:0], BANDGAP_WMASK);
		end
	end

	// Remembers the start bit of the last write so high-then-low is seen
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i)
			start_seen_r <= 1'b0;
		else if (wr_main)
			start_seen_r <= hwdata_i[BIT_START];
	end

	// Conversion clock divider, restarted at each start pulse
	// Seven-bit counter covers the largest divisor of 128
	assign div_limit = 7'((8'h01 << div_sel) - 8'h01);
	assign tick = (div_cnt_r == div_limit);

	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i || start_pulse || !main_r[BIT_ENABLE]) begin
			div_cnt_r  <= 7'h00;
			conv_clk_r <= 1'b0;
		end else if (tick) begin
			div_cnt_r  <= 7'h00;
			conv_clk_r <= ~conv_clk_r;
		end else begin
			div_cnt_r <= div_cnt_r + 7'h01;
		end
	end

	assign bit_idx = 4'(MSB_INDEX - 4'(step_r - SAMPLE_CLKS));

	// Last tick of each phase; the done pulse shares the end condition
	assign sample_last = tick && (step_r == SAMPLE_CLKS - 5'h01);
	assign conv_last   = tick && (step_r == CONV_BIT_CLKS - 5'h01);

	// Sequencer: two sample steps, then twelve trial bits MSB first
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			state_r <= ACS_IDLE;
			step_r  <= 5'h00;
			sar_r   <= 12'h000;
			data_r  <= 12'h000;
		end else if (!main_r[BIT_ENABLE]) begin
			state_r <= ACS_IDLE;
			step_r  <= 5'h00;
		end else begin
			unique case (state_r)
			ACS_IDLE: begin
				if (start_pulse) begin
					state_r <= ACS_SAMPLE;
					step_r  <= 5'h00;
					sar_r   <= 12'h000;
				end
			end
			ACS_SAMPLE: begin
				if (tick) begin
					step_r <= step_r + 5'h01;
					if (sample_last)
						state_r <= ACS_CONVERT;
				end
			end
			ACS_CONVERT: begin
				if (tick) begin
					sar_r[bit_idx] <= sar_bit_i;
					step_r <= step_r + 5'h01;
					if (conv_last) begin
						state_r <= ACS_IDLE;
						data_r  <= {sar_r[11:1], sar_bit_i};
					end
				end
			end
			endcase
		end
	end

	// An abort by disabling also drops busy, since the sequencer idles
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i)
			busy_r <= 1'b0;
		else if (start_pulse)
			busy_r <= 1'b1;
		else if (state_r == ACS_IDLE && !start_pulse)
			busy_r <= 1'b0;
	end

	// One-cycle end of conversion request toward the interrupt controller
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i)
			irq_r <= 1'b0;
		else
			irq_r <= main_r[BIT_ENABLE] && state_r == ACS_CONVERT
				&& conv_last;
	end

	// Packing is reapplied every enabled cycle so a format change takes effect
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			result_r <= '0;
		end else if (main_r[BIT_ENABLE]) begin
			if (main_r[BIT_FORMAT]) begin
				result_r.high <= {4'h0, data_r[11:8]};
				result_r.low  <= data_r[7:0];
			end else begin
				result_r.high <= data_r[11:4];
				result_r.low  <= {data_r[3:0], 4'h0};
			end
		end
	end

	always_comb begin
		analog_nxt = '0;
		analog_nxt.converter_on = main_r[BIT_ENABLE];
		unique casez (src_sel)
		4'b0000, 4'b0100, 4'b11??: analog_nxt.source = ACS_SRC_EXT;
		4'b0001: analog_nxt.source = ACS_SRC_VDD;
		4'b0010: analog_nxt.source = ACS_SRC_VDD2;
		4'b0011: analog_nxt.source = ACS_SRC_VDD4;
		4'b0101: analog_nxt.source = ACS_SRC_AMP;
		4'b0110: analog_nxt.source = ACS_SRC_AMP2;
		4'b0111: analog_nxt.source = ACS_SRC_AMP4;
		default: analog_nxt.source = ACS_SRC_GND;
		endcase
		// Codes 1000..1111 leave the input floating
		analog_nxt.channel_connect = (analog_nxt.source == ACS_SRC_EXT)
			&& !chan_none && main_r[BIT_ENABLE];
		analog_nxt.channel = chan_sel;
		unique casez (ref_sel)
		2'b00: analog_nxt.reference = ACS_REF_SUPPLY;
		2'b01: analog_nxt.reference = ACS_REF_PIN;
		default: analog_nxt.reference = ACS_REF_AMP;
		endcase
		analog_nxt.ref_pin_connect =
			(analog_nxt.reference == ACS_REF_PIN);
		analog_nxt.amp_on = amp_en;
		analog_nxt.amp_from_bandgap = amp_in_sel;
		analog_nxt.amp_pin_connect = !amp_in_sel;
		analog_nxt.gain = gain_sel;
		analog_nxt.bandgap_on = bg_en;
	end

	// Registered so the analog switches see one settled code per cycle
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i)
			analog_r <= '0;
		else
			analog_r <= analog_nxt;
	end

	// Read data is registered during the address phase
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i)
			hrdata_r <= 32'h0000_0000;
		else if (addr_ok && !hwrite_i) begin
			// Start is a strobe and reads back as zero
			if (sel_reg(haddr_i, OFF_MAIN))
				hrdata_r <= {24'h00_0000, 1'b0, busy_r, main_r[5:0]};
			else if (sel_reg(haddr_i, OFF_INCLK))
				hrdata_r <= {24'h00_0000, inclk_r};
			else if (sel_reg(haddr_i, OFF_REFGAIN))
				hrdata_r <= {24'h00_0000, refgain_r};
			else if (sel_reg(haddr_i, OFF_BANDGAP))
				hrdata_r <= {24'h00_0000, bandgap_r};
			else if (haddr_i == ADDR_RESULT)
				hrdata_r <= {16'h0000, result_r.high, result_r.low};
			else
				hrdata_r <= 32'h0000_0000;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			conv_done_irq_o <= 1'b0;
			sample_o        <= 1'b0;
			sar_trial_o     <= 1'b0;
			sar_code_o      <= 12'h000;
			conv_clk_o      <= 1'b0;
		end else begin
			conv_done_irq_o <= irq_r;
			sample_o        <= (state_r == ACS_SAMPLE);
			sar_trial_o     <= (state_r == ACS_CONVERT);
			sar_code_o      <= sar_r;
			conv_clk_o      <= conv_clk_r;
		end
	end

	assign hrdata_o      = hrdata_r;
	assign hreadyout_o   = 1'b1;
	assign hresp_o       = 1'b0;
	assign analog_ctrl_o = analog_r;
	assign result_o      = result_r;
endmodule

`default_nettype wire

/* verilog/acs_pkg.sv */
// Package for the converter control sequencer: offsets, fields, types
package acs_pkg;
	localparam logic [3:0]  OFF_MAIN      = 4'h0;
	localparam logic [3:0]  OFF_INCLK     = 4'h4;
	localparam logic [3:0]  OFF_REFGAIN   = 4'h8;
	localparam logic [3:0]  OFF_BANDGAP   = 4'hC;
	localparam logic [3:0]  OFF_RESULT    = 4'h0;
	localparam logic [11:0] ADDR_RESULT   = 12'h010;
	localparam int          BIT_START     = 7;
	localparam int          BIT_BUSY      = 6;
	localparam int          BIT_ENABLE    = 5;
	localparam int          BIT_FORMAT    = 4;
	// Field positions inside the control registers
	localparam int          FLD_CHAN      = 0;
	localparam int          BIT_NO_CHAN   = 3;
	localparam int          FLD_SRC       = 4;
	localparam int          FLD_DIV       = 0;
	localparam int          FLD_GAIN      = 0;
	localparam int          FLD_REF       = 2;
	localparam int          BIT_AMP_IN    = 4;
	localparam int          BIT_AMP_EN    = 7;
	localparam int          BIT_BG_EN     = 0;
	localparam logic [7:0]  MAIN_WMASK    = 8'hBF;
	localparam logic [7:0]  INCLK_WMASK   = 8'hF7;
	localparam logic [7:0]  REFGAIN_WMASK = 8'h9F;
	localparam logic [7:0]  BANDGAP_WMASK = 8'h01;
	localparam logic [7:0]  REG_RESET     = 8'h00;
	// Successive approximation: one converter clock half period per bit plus two for sample
	localparam logic [4:0]  CONV_BIT_CLKS = 5'h0E;
	localparam logic [4:0]  SAMPLE_CLKS   = 5'h02;
	localparam logic [3:0]  MSB_INDEX     = 4'hB;
	localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0]  HSIZE_WORD    = 3'h2;

	typedef enum logic [2:0] {
		ACS_SRC_EXT,
		ACS_SRC_VDD,
		ACS_SRC_VDD2,
		ACS_SRC_VDD4,
		ACS_SRC_AMP,
		ACS_SRC_AMP2,
		ACS_SRC_AMP4,
		ACS_SRC_GND
	} acs_src_t;

	typedef enum logic [1:0] {
		ACS_REF_SUPPLY,
		ACS_REF_PIN,
		ACS_REF_AMP
	} acs_ref_t;

	typedef struct packed {
		logic       converter_on;
		acs_src_t   source;
		logic       channel_connect;
		logic [2:0] channel;
		acs_ref_t   reference;
		logic       ref_pin_connect;
		logic       amp_on;
		logic       amp_from_bandgap;
		logic       amp_pin_connect;
		logic [1:0] gain;
		logic       bandgap_on;
	} acs_analog_t;

	typedef struct packed {
		logic [7:0] high;
		logic [7:0] low;
	} acs_result_t;
endpackage

/* sim/acs_sequencer_props.sv */
// Port checker for the converter control sequencer
`timescale 1ns/10ps
`default_nettype none
module acs_sequencer_chk
	import acs_pkg::*;
(
	input wire logic                 ref_clk_i,
	input wire logic                 nrst_i,
	input wire logic                 hreadyout_o,
	input wire logic                 hresp_o,
	input wire logic                 sample_o,
	input wire logic                 sar_trial_o,
	input wire logic                 conv_done_irq_o,
	input wire acs_pkg::acs_analog_t analog_ctrl_o,
	input wire acs_pkg::acs_result_t result_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!nrst_i);
	chk_bus_okay: assert property (!hresp_o && hreadyout_o)
		else $error("bus answer not ready or not okay");
	chk_irq_single: assert property (conv_done_irq_o |=> !conv_done_irq_o)
		else $error("done pulse longer than one cycle");
	chk_phase_split: assert property (!(sample_o && sar_trial_o))
		else $error("sampling and trials overlap");
	chk_off_idle: assert property (!analog_ctrl_o.converter_on [*3] |->
		!sample_o && !sar_trial_o && !conv_done_irq_o)
		else $error("conversion activity while disabled");
	chk_result_hold: assert property (!analog_ctrl_o.converter_on
		|-> $stable(result_o))
		else $error("result changed while disabled");
	chk_channel_gate: assert property (analog_ctrl_o.channel_connect |->
		analog_ctrl_o.source == ACS_SRC_EXT)
		else $error("channel connected with internal source");
	chk_ref_pin: assert property (analog_ctrl_o.ref_pin_connect ==
		(analog_ctrl_o.reference == ACS_REF_PIN))
		else $error("reference pin switch wrong");
	chk_amp_pin: assert property (analog_ctrl_o.amp_from_bandgap |->
		!analog_ctrl_o.amp_pin_connect)
		else $error("amplifier pin left on with bandgap");
	chk_reset_clear: assert property ($rose(nrst_i) |->
		result_o == 16'h0000 && !conv_done_irq_o)
		else $error("outputs not clear after reset");
	cov_done: cover property (conv_done_irq_o);
	cov_trial: cover property (sar_trial_o);
	cov_chan: cover property (analog_ctrl_o.channel_connect);
endmodule
bind acs_sequencer acs_sequencer_chk chk_u (.ref_clk_i, .nrst_i,
	.hreadyout_o, .hresp_o, .sample_o, .sar_trial_o, .conv_done_irq_o,
	.analog_ctrl_o, .result_o);
`default_nettype wire

/* sim/testbench.sv */
// Self-checking testbench for the converter control sequencer
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import acs_pkg::*;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic        hsel = 1'b0;
	logic [11:0] haddr = 12'h000;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h0;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [31:0] hrdata;
	logic        hrdy;
	logic        cclk;
	logic        irq;
	acs_analog_t an;
	acs_result_t res;
	logic [31:0] q;
	logic        sar_bit = 1'b0;
	logic [11:0] sar_code;
	int          n_fail = 0;
	int          compares = 0;
	always #25 clk = ~clk;
	acs_sequencer dut_u (.ref_clk_i(clk), .nrst_i(nrst), .hsel_i(hsel),
		.haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
		.hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hrdy),
		.sar_bit_i(sar_bit), .hrdata_o(hrdata), .hreadyout_o(hrdy),
		.hresp_o(), .conv_clk_o(cclk), .sample_o(), .sar_trial_o(),
		.sar_code_o(sar_code), .conv_done_irq_o(irq), .analog_ctrl_o(an),
		.result_o(res));
	task automatic close_out();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// Called just after a rising edge; holds each phase until hready
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		hsize <= HSIZE_WORD;
		htrans <= HTRANS_NONSEQ;
		do @(posedge clk); while (hrdy !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hrdy !== 1'b1);
		q = hrdata;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0000_0000);
		cmp(q, exp);
	endtask
	task automatic t_regs();
		for (int i = 0; i < 4; i++)
			rd(12'(i * 4), 32'h0000_0000);
		wr(12'h004, 32'h0000_00FF);
		rd(12'h004, 32'h0000_00F7);
		wr(12'h008, 32'h0000_00FF);
		rd(12'h008, 32'h0000_009F);
		wr(12'h00C, 32'h0000_00FF);
		rd(12'h00C, 32'h0000_0001);
		cmp({31'h0, an.bandgap_on}, 32'h0000_0001);
		wr(12'h020, 32'h0000_00FF);
		rd(12'h020, 32'h0000_0000);
		wr(12'h004, 32'h0000_0000);
		wr(12'h008, 32'h0000_0000);
	endtask
	task automatic t_src();
		logic [3:0] c;
		logic [2:0] e;
		wr(12'h000, 32'h0000_0023);
		wr(12'h008, 32'h0000_0080);
		for (int i = 0; i < 16; i++) begin
			c = 4'(i);
			e = 3'(c[1:0]) + (c[2] ? 3'h3 : 3'h0);
			if (c[3])
				e = c[2] ? 3'h0 : 3'h7;
			else if (c[1:0] == 2'h0)
				e = 3'h0;
			wr(12'h004, {24'h0, c, 4'h0});
			repeat (3) @(posedge clk);
			cmp({28'h0, an.source, an.channel_connect}, {28'h0, e, e == 3'h0});
		end
		cmp({29'h0, an.channel}, 32'h0000_0003);
		wr(12'h000, 32'h0000_002B);
		repeat (3) @(posedge clk);
		cmp({31'h0, an.channel_connect}, 32'h0000_0000);
		wr(12'h004, 32'h0000_0000);
	endtask
	task automatic t_ref();
		wr(12'h00C, 32'h0000_0001);
		for (int r = 0; r < 4; r++) begin
			wr(12'h008, 32'(8'h90 | 8'(r << 2) | 8'(r)));
			repeat (3) @(posedge clk);
			cmp(32'({an.reference, an.ref_pin_connect, an.amp_on,
				an.amp_from_bandgap, an.amp_pin_connect, an.gain}),
				32'({(r > 1) ? 2'h2 : 2'(r), r == 1, 3'h6, 2'(r)}));
		end
		wr(12'h008, 32'h0000_0080);
		repeat (3) @(posedge clk);
		cmp({31'h0, an.amp_from_bandgap}, 32'h0000_0000);
		wr(12'h008, 32'h0000_0000);
	endtask
	// The first interval after a code change may be partial, so skip it
	task automatic t_div();
		int n;
		logic p;
		wr(12'h000, 32'h0000_0020);
		for (int c = 0; c < 8; c++) begin
			wr(12'h004, 32'(c));
			for (int k = 0; k < 3; k++) begin
				p = cclk;
				n = 0;
				while (cclk === p && n < 300) begin
					@(posedge clk);
					n++;
				end
			end
			cmp(32'(n), 32'(1 << c));
		end
		wr(12'h004, 32'h0000_0000);
	endtask
	task automatic t_conv(input logic [7:0] f, input logic [11:0] pat,
		input logic [31:0] exp);
		int n;
		wr(12'h000, 32'(8'hA0 | f));
		wr(12'h000, 32'(8'h20 | f));
		rd(12'h000, 32'(8'h60 | f));
		// Clock code 000: after two sample ticks one trial bit per cycle
		sar_bit <= pat[11];
		for (int i = 10; i >= 0; i--) begin
			@(posedge clk);
			sar_bit <= pat[i];
		end
		n = 0;
		while (irq !== 1'b1 && n < 3000) begin
			@(posedge clk);
			n++;
		end
		cmp(32'(n < 3000), 32'h0000_0001);
		repeat (4) @(posedge clk);
		rd(12'h000, 32'(8'h20 | f));
		rd(12'h010, exp);
		cmp(32'(res), exp);
		cmp({20'h0, sar_code}, {20'h0, pat});
	endtask
	task automatic t_off();
		wr(12'h000, 32'h0000_0080);
		wr(12'h000, 32'h0000_0000);
		rd(12'h000, 32'h0000_0000);
		repeat (40) @(posedge clk);
		cmp(32'(res), 32'h0000_05A3);
		cmp({31'h0, an.converter_on}, 32'h0000_0000);
	endtask
	initial begin
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		t_regs();
		t_src();
		t_ref();
		t_div();
		t_conv(8'h00, 12'hA5C, 32'h0000_A5C0);
		t_conv(8'h10, 12'h5A3, 32'h0000_05A3);
		t_off();
		close_out();
	end
	initial begin
		#2000000;
		n_fail++;
		close_out();
	end
endmodule
`default_nettype wire
